// file: tsfd_consts.vh
/*
 * Constants for the two-stage fractional output divider: register window,
 * field positions, reset values and widths.
 * Assumes inclusion by tsfd_divider.v only; holds definitions and nothing else.
 */
`ifndef TSFD_CONSTS_VH
`define TSFD_CONSTS_VH

// ----------------------------------------------------------------------
// Register window
// ----------------------------------------------------------------------
`define TSFD_ADDR_W          12
`define TSFD_BASE            12'h110
`define TSFD_RATIO_OFS       12'h000
`define TSFD_PHASE_OFS       12'h008
`define TSFD_RATIO_BYTES     4'h8
`define TSFD_PHASE_BYTES     4'h2

// ----------------------------------------------------------------------
// Ratio/configuration register fields
// ----------------------------------------------------------------------
`define TSFD_RATIO_RST       64'h0000000000000064
`define TSFD_INT_RST         9'h064
`define TSFD_PD_BIT          63
`define TSFD_DIS_BIT         62
`define TSFD_RST_BIT         61
`define TSFD_ACC_BIT         60
`define TSFD_FRAC_HI         59
`define TSFD_FRAC_LO         26
`define TSFD_HALF_HI         25
`define TSFD_HALF_LO         9
`define TSFD_INT_HI          8
`define TSFD_INT_LO          0
`define TSFD_INT_TOP_BYTE    3'h1
`define TSFD_FRAC_TOP_BYTE   3'h7

// ----------------------------------------------------------------------
// Phase configuration register fields
// ----------------------------------------------------------------------
`define TSFD_PHASE_RST       16'h43F0
`define TSFD_PHASE_RD_MASK   16'hE3FF
`define TSFD_PH_RST          10'h3F0
`define TSFD_PH_WBYTE_HI     14
`define TSFD_PH_WBYTE_LO     8
`define TSFD_TRIG_BIT        15
`define TSFD_POST_SYNC_BIT   14
`define TSFD_PH_HI           9
`define TSFD_PH_LO           0
`define TSFD_PH_TOP_BYTE     1'b1
`define TSFD_TRIG_WBIT       7

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define TSFD_FRAC_W          34
`define TSFD_INT_W           9
`define TSFD_HALF_W          17
`define TSFD_PH_W            10
`define TSFD_CNT_W           12
`define TSFD_BYTE_W          8
`define TSFD_RATIO_LANES     8

`endif

// file: tsfd_divider.v
/*
 * Two-stage fractional output divider: byte-wide register port, atomic
 * ratio and phase commit, first-order sigma-delta multi-modulus first stage,
 * optional even second stage, power-down, disable, reset and phase adjust.
 * Assumes a same-clock register master that never issues read and write
 * together; the clock input stands in for the high-frequency source.
 */
`include "tsfd_consts.vh"

// Operation
// - Power-down bit stops the divider; software pairs it with divider reset.
// - Disable bit stops the divider; software pairs it with divider reset.
// - Divider reset bit holds the divider in reset while 1; resets to 0.
// - Accumulator-reset bit at 1 clears the sigma-delta accumulator; 0 releases it.
// - Fraction is 34 bits over a fixed denominator of two to the 34th.
// - Writing the fraction top byte commits integer and fraction together.
// - Half-ratio zero bypasses the second stage.
// - First stage is multi-modulus with 9-bit integer ratio, default one hundred.
// - Writing the integer top byte also commits the integer and fraction group.
// - Ratio register at base plus zero, phase register at base plus eight.
// - Phase-adjust trigger applies the phase offset, self-clearing when done.
module tsfd_divider (
   // Clock and reset
   input  wire                     clock,
   input  wire                     sys_rst,
   // Register port
   input  wire [`TSFD_ADDR_W-1:0]  reg_addr,
   input  wire [7:0]               reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output wire [7:0]               reg_rdata,
   // Divider outputs
   output wire                     div_clk_out,
   output wire                     stage1_pulse,
   output wire                     div_running,
   output wire                     phase_busy
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   reg  [63:0]              cfg_reg;
   reg  [63:0]              cfg_next;
   reg  [15:0]              ph_reg;
   reg  [15:0]              ph_next;
   reg  [`TSFD_INT_W-1:0]   int_act_reg;
   reg  [`TSFD_FRAC_W-1:0]  frac_act_reg;
   reg  [`TSFD_PH_W-1:0]    phase_act_reg;
   reg  [`TSFD_FRAC_W-1:0]  acc_reg;
   reg  [`TSFD_CNT_W-1:0]   cnt1_reg;
   reg  [`TSFD_HALF_W-1:0]  cnt2_reg;
   reg                      pulse_reg;
   reg                      out2_reg;
   reg                      clk_out_reg;
   reg                      hold_d_reg;
   reg                      sync_pend_reg;
   reg  [7:0]               rdata_reg;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   wire [`TSFD_ADDR_W-1:0]  ofs = reg_addr - `TSFD_BASE;
   wire                     hit_ratio = (reg_addr >= `TSFD_BASE) &&
                                        (ofs < `TSFD_RATIO_OFS + `TSFD_RATIO_BYTES);
   wire                     hit_phase = (reg_addr >= `TSFD_BASE) &&
                                        (ofs >= `TSFD_PHASE_OFS) &&
                                        (ofs < `TSFD_PHASE_OFS + `TSFD_PHASE_BYTES);
   wire [2:0]               ratio_byte = ofs[2:0];
   wire                     phase_byte = ofs[0];
   wire                     wr_ratio = reg_wr && hit_ratio;
   wire                     wr_phase = reg_wr && hit_phase;

   // Either top byte commits the whole ratio group at once
   wire commit_ratio = wr_ratio && ((ratio_byte == `TSFD_INT_TOP_BYTE) ||
                                    (ratio_byte == `TSFD_FRAC_TOP_BYTE));
   wire commit_phase = wr_phase && (phase_byte == `TSFD_PH_TOP_BYTE);

   // ----------------------------------------------------------------------
   // Divider control decode
   // ----------------------------------------------------------------------
   wire hold = cfg_reg[`TSFD_RST_BIT] | cfg_reg[`TSFD_PD_BIT] |
               cfg_reg[`TSFD_DIS_BIT];
   wire acc_clear = hold | cfg_reg[`TSFD_ACC_BIT];
   wire [`TSFD_HALF_W-1:0] half = cfg_reg[`TSFD_HALF_HI:`TSFD_HALF_LO];
   wire bypass = (half == {`TSFD_HALF_W{1'b0}});
   wire trig = ph_reg[`TSFD_TRIG_BIT];

   // ----------------------------------------------------------------------
   // First stage: sigma-delta steered multi-modulus count
   // ----------------------------------------------------------------------
   // The carry out of a 34-bit accumulator adds one count, so the long-run
   // ratio is integer + frac / 2^34.
   wire [`TSFD_FRAC_W:0]   acc_sum = {1'b0, acc_reg} + {1'b0, frac_act_reg};
   wire                    carry   = acc_sum[`TSFD_FRAC_W];
   wire                    reload  = (cnt1_reg <= {{(`TSFD_CNT_W-1){1'b0}}, 1'b1});
   wire                    adj_now = trig | sync_pend_reg;

   // Phase steps are a quarter source period; the count can only move by
   // whole periods, so the offset is rounded toward minus infinity.
   wire signed [`TSFD_CNT_W-1:0] ph_steps =
      {{(`TSFD_CNT_W-`TSFD_PH_W+2){phase_act_reg[`TSFD_PH_W-1]}},
       phase_act_reg[`TSFD_PH_W-1:2]};
   wire signed [`TSFD_CNT_W-1:0] base_cnt =
      $signed({{(`TSFD_CNT_W-`TSFD_INT_W){1'b0}}, int_act_reg}) +
      $signed({{(`TSFD_CNT_W-1){1'b0}}, carry});
   wire signed [`TSFD_CNT_W-1:0] adj_cnt = adj_now ? base_cnt + ph_steps : base_cnt;
   wire signed [`TSFD_CNT_W-1:0] one_cnt = {{(`TSFD_CNT_W-1){1'b0}}, 1'b1};
   wire [`TSFD_CNT_W-1:0]        load_cnt = (adj_cnt < one_cnt) ? one_cnt : adj_cnt;

   // ----------------------------------------------------------------------
   // Ratio byte lanes
   // ----------------------------------------------------------------------
   // One strobe per lane keeps the decode flat; only the addressed lane
   // takes the write byte, the others hold their buffered value
   wire [`TSFD_RATIO_LANES-1:0] lane_sel = {{(`TSFD_RATIO_LANES-1){1'b0}}, 1'b1} << ratio_byte;
   wire [`TSFD_RATIO_LANES-1:0] lane_wr;
   wire [63:0]                  cfg_lane_val;
   genvar                       lane;

   generate
      for (lane = 0; lane < `TSFD_RATIO_LANES; lane = lane + 1) begin : g_lane
         assign lane_wr[lane] = wr_ratio && lane_sel[lane];
         assign cfg_lane_val[lane*`TSFD_BYTE_W +: `TSFD_BYTE_W] =
            lane_wr[lane] ? reg_wdata : cfg_reg[lane*`TSFD_BYTE_W +: `TSFD_BYTE_W];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------------
   always @* begin
      cfg_next = cfg_lane_val;
      ph_next  = ph_reg;
      if (!hold && reload && trig) begin
         ph_next[`TSFD_TRIG_BIT] = 1'b0;
      end
      if (wr_phase) begin
         if (phase_byte == `TSFD_PH_TOP_BYTE) begin
            ph_next[`TSFD_PH_WBYTE_HI:`TSFD_PH_WBYTE_LO] =
               reg_wdata[`TSFD_PH_WBYTE_HI-`TSFD_PH_WBYTE_LO:0];
            // Write-one-to-set; a set always wins over completion
            if (reg_wdata[`TSFD_TRIG_WBIT]) begin
               ph_next[`TSFD_TRIG_BIT] = 1'b1;
            end
         end else begin
            ph_next[7:0] = reg_wdata;
         end
      end
   end

   always @(posedge clock) begin
      if (sys_rst) begin
         cfg_reg       <= `TSFD_RATIO_RST;
         ph_reg        <= `TSFD_PHASE_RST;
         int_act_reg   <= `TSFD_INT_RST;
         frac_act_reg  <= {`TSFD_FRAC_W{1'b0}};
         phase_act_reg <= `TSFD_PH_RST;
      end else begin
         cfg_reg <= cfg_next;
         ph_reg  <= ph_next;
         if (commit_ratio) begin
            int_act_reg  <= cfg_next[`TSFD_INT_HI:`TSFD_INT_LO];
            frac_act_reg <= cfg_next[`TSFD_FRAC_HI:`TSFD_FRAC_LO];
         end
         if (commit_phase) begin
            phase_act_reg <= ph_next[`TSFD_PH_HI:`TSFD_PH_LO];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------------
   wire [15:0] ph_view = ph_reg & `TSFD_PHASE_RD_MASK;

   always @(posedge clock) begin
      if (sys_rst) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd && hit_ratio) begin
         rdata_reg <= cfg_reg[{ratio_byte, 3'h0} +: 8];
      end else if (reg_rd && hit_phase) begin
         rdata_reg <= phase_byte ? ph_view[15:8] : ph_view[7:0];
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // Divider datapath
   // ----------------------------------------------------------------------
   always @(posedge clock) begin
      if (sys_rst) begin
         acc_reg       <= {`TSFD_FRAC_W{1'b0}};
         cnt1_reg      <= {`TSFD_CNT_W{1'b0}};
         cnt2_reg      <= {`TSFD_HALF_W{1'b0}};
         pulse_reg     <= 1'b0;
         out2_reg      <= 1'b0;
         clk_out_reg   <= 1'b0;
         hold_d_reg    <= 1'b0;
         sync_pend_reg <= 1'b0;
      end else begin
         hold_d_reg  <= hold;
         clk_out_reg <= bypass ? pulse_reg : out2_reg;
         if (acc_clear) begin
            acc_reg <= {`TSFD_FRAC_W{1'b0}};
         end else if (reload) begin
            acc_reg <= acc_sum[`TSFD_FRAC_W-1:0];
         end
         // Release from hold counts as a synchronisation event
         if (hold_d_reg && !hold && ph_reg[`TSFD_POST_SYNC_BIT]) begin
            sync_pend_reg <= 1'b1;
         end else if (!hold && reload) begin
            sync_pend_reg <= 1'b0;
         end
         if (hold) begin
            // Output static and counters cleared so release starts clean
            cnt1_reg  <= {`TSFD_CNT_W{1'b0}};
            cnt2_reg  <= {`TSFD_HALF_W{1'b0}};
            pulse_reg <= 1'b0;
            out2_reg  <= 1'b0;
         end else begin
            pulse_reg <= reload;
            if (reload) begin
               cnt1_reg <= load_cnt;
            end else begin
               cnt1_reg <= cnt1_reg - {{(`TSFD_CNT_W-1){1'b0}}, 1'b1};
            end
            // Toggle every half first-stage pulses: ratio 2 * half
            if (bypass) begin
               cnt2_reg <= {`TSFD_HALF_W{1'b0}};
               out2_reg <= 1'b0;
            end else if (pulse_reg) begin
               if (cnt2_reg <= {{(`TSFD_HALF_W-1){1'b0}}, 1'b1}) begin
                  cnt2_reg <= half;
                  out2_reg <= ~out2_reg;
               end else begin
                  cnt2_reg <= cnt2_reg - {{(`TSFD_HALF_W-1){1'b0}}, 1'b1};
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign reg_rdata    = rdata_reg;
   assign div_clk_out  = clk_out_reg;
   assign stage1_pulse = pulse_reg;
   assign div_running  = ~hold_d_reg;
   assign phase_busy   = trig | sync_pend_reg;

endmodule // tsfd_divider

// file: tsfd_divider_props.sv
/*
 * Port-level properties of tsfd_divider, bound into every instance.
 * Assumes one clock and a synchronous active-high sys_rst.
 */
module tsfd_divider_props (
   // Clock and reset
   input wire logic        clock,
   input wire logic        sys_rst,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   // Divider outputs
   input wire logic        div_clk_out,
   input wire logic        stage1_pulse,
   input wire logic        div_running,
   input wire logic        phase_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire ctl_wr = reg_wr && reg_addr == 12'h117;
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   AST_RD_IDLE:
      assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read slot");
   AST_UNMAPPED:
      assert property (reg_rd && (reg_addr < 12'h110 || reg_addr > 12'h119)
         |=> reg_rdata == 8'h00) else $error("unmapped read returned data");
   AST_HOLD_SET:
      assert property (ctl_wr && reg_wdata[7:5] != 3'h0 |-> ##2 !div_running)
      else $error("divider still running after hold write");
   AST_HOLD_CLR:
      assert property (ctl_wr && reg_wdata[7:5] == 3'h0 |-> ##2 div_running)
      else $error("divider not running after hold release");
   // Output register lags one cycle, so only settled hold is judged
   AST_HOLD_STATIC:
      assert property (!div_running && !$past(div_running) |-> !stage1_pulse && !div_clk_out)
      else $error("divider output moved while held");
   AST_RESTART:
      assert property ($rose(div_running) && !$past(sys_rst) |-> stage1_pulse)
      else $error("no first pulse after hold release");
   AST_PULSE_GAP:
      assert property (stage1_pulse |=> !stage1_pulse [*2])
      else $error("first stage pulses too close");
   AST_TRIG_BUSY:
      assert property (reg_wr && reg_addr == 12'h119 && reg_wdata[7] |=> phase_busy)
      else $error("phase trigger not pending after write");
   cover property ($rose(div_running) && stage1_pulse);
   cover property (stage1_pulse ##1 div_clk_out);
   cover property ($fell(phase_busy));
endmodule // tsfd_divider_props

bind tsfd_divider tsfd_divider_props u_props (
   .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .div_clk_out(div_clk_out),
   .stage1_pulse(stage1_pulse), .div_running(div_running), .phase_busy(phase_busy));

// file: tsfd_divider_tb.sv
/*
 * Self-checking bench for tsfd_divider: register map, hold controls,
 * ratio commit, fraction, second stage and phase trigger.
 * Assumes the byte-wide register port; the bench is the only master.
 */
module tsfd_divider_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock;
   logic        sys_rst = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00;
   wire  [7:0]  reg_rdata;
   wire         div_clk_out, stage1_pulse, div_running, phase_busy;
   int          bad_count = 0, n_tests = 0, i, t;
   // Row: write flag, address, write data, expected read
   localparam bit [31:0] ROWS [14] = '{32'h01100064, 32'h01110000, 32'h01160000,
      32'h01170000, 32'h011800F0, 32'h01190043, 32'h011A0000, 32'h010F0000, 32'h1112A5A5,
      32'h11120000, 32'h11191F03, 32'h111AFF00, 32'h11153C3C, 32'h11150000};
   tsfd_divider DUT (
      .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .div_clk_out(div_clk_out),
      .stage1_pulse(stage1_pulse), .div_running(div_running), .phase_busy(phase_busy));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // ----------------------------------------------------------------
   // Bus and measurement tasks
   // ----------------------------------------------------------------
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
   endtask
   // Bounded wait for pulse (0), output (1) or busy (2) to reach v
   task automatic wsig(input int s, input logic v, output int c);
      for (c = 0; c < 2000 && (s == 2 ? phase_busy : s == 1 ? div_clk_out
            : stage1_pulse) !== v; c++) begin
         @(posedge clock);
         #1;
      end
   endtask
   task automatic per(input int k, input logic [15:0] e);
      int c, w;
      // Skip the period that may have been loaded before the change
      #1 wsig(0, 1'b1, w);
      @(posedge clock);
      #1 wsig(0, 1'b1, w);
      c = 0;
      repeat (k) begin
         @(posedge clock);
         #1 wsig(0, 1'b1, w);
         c += w + 1;
      end
      chk("pulse span", e, c[15:0]);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      report_and_stop;
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      for (i = 0; i < 14; i++) begin
         if (ROWS[i][28]) wr(ROWS[i][27:16], ROWS[i][15:8]);
         rd(ROWS[i][27:16], ROWS[i][7:0]);
      end
      done("register map");
      // Reset alone, then disable and power-down each paired with reset
      for (i = 5; i < 8; i++) begin
         wr(12'h117, 8'h20 | (8'h01 << i));
         @(posedge clock);
         #1 chk("div_running", 16'h0000, {15'h0, div_running});
         repeat (3) @(posedge clock);
         #1 chk("held outputs", 16'h0000, {14'h0, stage1_pulse, div_clk_out});
         wr(12'h117, 8'h20);
         wr(12'h117, 8'h00);
         @(posedge clock);
         #1 chk("first pulse", 16'h0001, {15'h0, stage1_pulse});
      end
      done("hold controls");
      wsig(0, 1'b1, t);
      @(posedge clock);
      #1 chk("bypass out", 16'h0001, {15'h0, div_clk_out});
      wr(12'h110, 8'h0A);
      per(1, 16'h0064);
      wr(12'h111, 8'h00);
      per(1, 16'h000A);
      wr(12'h117, 8'h08);
      per(2, 16'h0015);
      wr(12'h110, 8'h0C);
      per(2, 16'h0015);
      wr(12'h111, 8'h00);
      per(2, 16'h0019);
      wr(12'h117, 8'h18);
      per(2, 16'h0018);
      wr(12'h117, 8'h08);
      done("ratio commit");
      wr(12'h111, 8'h04);
      wsig(1, 1'b0, t);
      wsig(1, 1'b1, t);
      wsig(1, 1'b0, t);
      chk("stage two high", 16'h0019, t[15:0]);
      wr(12'h119, 8'h83);
      #1 chk("phase_busy", 16'h0001, {15'h0, phase_busy});
      wsig(2, 1'b0, t);
      chk("busy cleared", 16'h0001, {15'h0, t < 30});
      rd(12'h119, 8'h03);
      // Post-sync adjust: a release from hold schedules one adjustment
      wr(12'h119, 8'h43);
      wr(12'h117, 8'h20);
      wr(12'h117, 8'h08);
      @(posedge clock);
      #1 chk("sync pending", 16'h0001, {15'h0, phase_busy});
      wsig(2, 1'b0, t);
      chk("sync cleared", 16'h0001, {15'h0, t < 30});
      rd(12'h119, 8'h43);
      done("stage two and phase");
      @(posedge clock);
      sys_rst <= 1'b1;
      @(posedge clock);
      sys_rst <= 1'b0;
      rd(12'h110, 8'h64);
      rd(12'h119, 8'h43);
      done("second reset");
      report_and_stop;
   end
endmodule // tsfd_divider_tb
